// file: lmon_host_model.sv
// Host side model issuing limit commands and reading answers
`timescale 1ns/10ps
module lmon_host_model
   import lmon_pkg::*;
(
   input wire logic mclk,
   input wire lmon_rsp_type rsp,
   output lmon_cmd_type cmd
);
   initial cmd = '0;

   // ********************************
   // Command transfer
   // ********************************
   // One whole 16-bit linear word per command
   task automatic xfer(input logic w, input logic p, input logic [7:0] c,
      input logic [15:0] d, output lmon_rsp_type r);
      cmd = '{valid: 1'b1, write: w, page: p, code: c, wdata: d};
      @(posedge mclk);
      #1;
      r = rsp;
      cmd = '0;
      @(posedge mclk);
      #1;
   endtask

   // No sensor fitted: undertemperature limit to -275 degrees
   task automatic no_sensor_setup(input logic p);
      lmon_rsp_type r;
      xfer(1'b1, p, CMD_UT_FAULT, 16'h06ed, r);
   endtask
endmodule

// file: lmon_limit_monitor.sv
// Current and temperature limit registers and comparators
`timescale 1ns/10ps
module lmon_limit_monitor
   import lmon_pkg::*;
#(
   parameter int RESPONSE_LIMIT_CYC = ADC_RESPONSE_MS * 1000 * CLK_MHZ
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire lmon_cmd_type cmd,
   output lmon_rsp_type rsp,
   input wire lmon_adc_type adc,
   input wire lmon_chan_cfg_type [NUM_CHAN-1:0] chan_cfg,
   input wire logic [NUM_CHAN-1:0] ramping,
   input wire logic [NUM_CHAN-1:0] current_limit_pin,
   input wire lmon_status_type alert_mask,
   output lmon_status_type [NUM_CHAN-1:0] chan_status,
   output logic [NUM_CHAN-1:0][2:0] oc_step,
   output logic alert_o,
   output logic alert_oe
);

   // ****************************************************************
   // Arithmetic helpers
   // ****************************************************************
   function automatic logic signed [FX_W-1:0] lin_to_fx(
      input logic [15:0] w);
      logic signed [FX_W-1:0] m;
      logic signed [6:0] sh;
      logic signed [FX_W-1:0] r;
      begin
         m = FX_W'(signed'(w[LIN_MANT_MSB:0])); // [RULE18]
         sh = 7'(signed'(w[LIN_EXP_MSB:LIN_EXP_LSB])) + 7'(FX_FRAC);
         if (sh >= 0)
         begin
            r = m <<< sh[5:0];
         end
         else
         begin
            r = m >>> 6'(-sh);
         end
         return r;
      end
   endfunction

   function automatic logic signed [FX_W-1:0] temp_calc(
      input logic [15:0] raw,
      input logic [15:0] slope,
      input logic [15:0] offs);
      logic [15:0] n;
      logic signed [BIG_W-1:0] p;
      begin
         n = slope;
         if (signed'(slope) < signed'(SLOPE_MIN))
         begin
            n = SLOPE_MIN; // [RULE11]
         end
         p = BIG_W'(lin_to_fx(raw)) * BIG_W'(signed'({1'b0, n}));
         p = p >>> SLOPE_SHIFT; // [RULE11]
         return FX_W'(p) + lin_to_fx(offs) + KELVIN_BASE_FX; // [RULE12]
      end
   endfunction

   function automatic logic [2:0] oc_step_sel(
      input logic range_high,
      input logic [15:0] limit,
      input lmon_chan_cfg_type cfg,
      input logic signed [FX_W-1:0] temp);
      logic signed [BIG_W-1:0] factor;
      logic signed [BIG_W-1:0] gain_eff;
      logic signed [BIG_W-1:0] sense;
      logic signed [BIG_W-1:0] step;
      logic [2:0] sel;
      begin
         factor = BIG_W'(PPM_UNITY_FX)
            + BIG_W'(signed'(cfg.sense_gain_temp_coefficient))
            * BIG_W'(temp - TC_NOMINAL_FX); // [RULE7]
         gain_eff = BIG_W'(lin_to_fx(cfg.current_sense_gain)) * factor
            / BIG_W'(PPM_UNITY_FX); // [RULE7]
         // Amperes times milliohms gives millivolts
         sense = (BIG_W'(lin_to_fx(limit)) * gain_eff) >>> FX_FRAC;
         sense = sense * BIG_W'(TENTHS); // [RULE19]
         sel = 3'h7;
         for (int i = 7; i >= 0; i--)
         begin
            if (range_high)
            begin
               step = BIG_W'(OC_STEP_HIGH[i]) <<< FX_FRAC; // [RULE4]
            end
            else
            begin
               step = BIG_W'(OC_STEP_LOW[i]) <<< FX_FRAC; // [RULE3]
            end
            if (sense <= step)
            begin
               sel = 3'(i); // [RULE3]
            end
         end
         return sel;
      end
   endfunction

   function automatic logic over(
      input logic signed [FX_W-1:0] a,
      input logic [15:0] lim);
      return a > lin_to_fx(lim);
   endfunction

   // ****************************************************************
   // Limit registers
   // ****************************************************************
   logic [NUM_CHAN-1:0][15:0] peak_q;
   logic [NUM_CHAN-1:0][15:0] owarn_q;
   logic [NUM_CHAN-1:0][15:0] otf_q;
   logic [NUM_CHAN-1:0][15:0] otw_q;
   logic [NUM_CHAN-1:0][15:0] utf_q;
   logic [NUM_CHAN-1:0][15:0] slope_q;
   logic [NUM_CHAN-1:0][15:0] offs_q;
   logic [15:0] iwarn_q;
   logic wr;

   assign wr = ce && cmd.valid && cmd.write;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            peak_q[c] <= RST_PEAK_FAULT;
            owarn_q[c] <= RST_OUT_WARN;
            otf_q[c] <= RST_OT_FAULT;
            otw_q[c] <= RST_OT_WARN;
            utf_q[c] <= RST_UT_FAULT;
            slope_q[c] <= RST_SLOPE_TRIM;
            offs_q[c] <= RST_OFFSET_TRIM;
         end
         iwarn_q <= RST_IN_WARN; // [RULE16]
      end
      else if (wr)
      begin
         case (cmd.code)
            CMD_PEAK_FAULT: peak_q[cmd.page] <= cmd.wdata;
            CMD_OUT_WARN: owarn_q[cmd.page] <= cmd.wdata;
            CMD_OT_FAULT: otf_q[cmd.page] <= cmd.wdata;
            CMD_OT_WARN: otw_q[cmd.page] <= cmd.wdata;
            CMD_UT_FAULT: utf_q[cmd.page] <= cmd.wdata;
            CMD_SLOPE_TRIM: slope_q[cmd.page] <= cmd.wdata;
            CMD_OFFSET_TRIM: offs_q[cmd.page] <= cmd.wdata;
            CMD_IN_WARN: iwarn_q <= cmd.wdata; // [RULE16]
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Command answers
   // ****************************************************************
   lmon_rsp_type rsp_q;
   lmon_rsp_type rsp_d;

   always_comb
   begin
      rsp_d.valid = cmd.valid;
      rsp_d.err = 1'b0;
      rsp_d.rdata = 16'h0000;
      case (cmd.code)
         CMD_PEAK_FAULT: rsp_d.rdata = peak_q[cmd.page];
         CMD_OUT_WARN: rsp_d.rdata = owarn_q[cmd.page];
         CMD_OT_FAULT: rsp_d.rdata = otf_q[cmd.page];
         CMD_OT_WARN: rsp_d.rdata = otw_q[cmd.page];
         CMD_UT_FAULT: rsp_d.rdata = utf_q[cmd.page];
         CMD_SLOPE_TRIM: rsp_d.rdata = slope_q[cmd.page];
         CMD_OFFSET_TRIM: rsp_d.rdata = offs_q[cmd.page];
         CMD_IN_WARN: rsp_d.rdata = iwarn_q; // [RULE16]
         CMD_CLEAR_STATUS: rsp_d.err = !cmd.write;
         default: rsp_d.err = 1'b1;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rsp_q <= '0;
      end
      else if (ce)
      begin
         rsp_q <= rsp_d;
      end
   end

   assign rsp = rsp_q;

   // ****************************************************************
   // Current limit pin synchroniser
   // ****************************************************************
   logic [NUM_CHAN-1:0] cl_meta_q;
   logic [NUM_CHAN-1:0] cl_sync_q;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cl_meta_q <= '0;
         cl_sync_q <= '0;
      end
      else if (ce)
      begin
         cl_meta_q <= current_limit_pin;
         cl_sync_q <= cl_meta_q;
      end
   end

   // ****************************************************************
   // Temperature and peak threshold step
   // ****************************************************************
   logic signed [NUM_CHAN-1:0][FX_W-1:0] temp_q;
   logic signed [FX_W-1:0] temp_d;
   logic [NUM_CHAN-1:0][2:0] step_q;

   assign temp_d = temp_calc(adc.value, slope_q[adc.chan],
      offs_q[adc.chan]);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         temp_q <= '0;
      end
      else if (ce && adc.valid && adc.kind == ADC_TEMP)
      begin
         temp_q[adc.chan] <= temp_d;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         step_q <= '0;
      end
      else if (ce)
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            step_q[c] <= oc_step_sel(
               chan_cfg[c].pwm_mode_config[RANGE_BIT], // [RULE5]
               peak_q[c], chan_cfg[c], temp_q[c]);
         end
      end
   end

   assign oc_step = step_q;

   // ****************************************************************
   // Limit evaluation and status
   // ****************************************************************
   lmon_status_type [NUM_CHAN-1:0] status_q;
   lmon_status_type [NUM_CHAN-1:0] set_d;
   logic signed [FX_W-1:0] sample_fx;
   logic clear;

   assign sample_fx = lin_to_fx(adc.value);
   assign clear = wr && cmd.code == CMD_CLEAR_STATUS;

   always_comb
   begin
      set_d = '0;
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         if (cl_sync_q[c] && !ramping[c]) // [RULE6] [RULE8]
         begin
            set_d[c].iout_oc_fault = 1'b1;
            set_d[c].word_iout = 1'b1;
         end
         if (adc.valid && adc.kind == ADC_IIN
            && over(sample_fx, iwarn_q)) // [RULE20]
         begin
            set_d[c].byte_other = 1'b1; // [RULE1]
            set_d[c].word_input = 1'b1;
            set_d[c].iin_oc_warn = 1'b1;
         end
      end
      if (adc.valid && adc.kind == ADC_IOUT
         && over(sample_fx, owarn_q[adc.chan])) // [RULE10] [RULE20]
      begin
         set_d[adc.chan].byte_none_above = 1'b1; // [RULE9]
         set_d[adc.chan].word_iout = 1'b1;
         set_d[adc.chan].iout_oc_warn = 1'b1;
      end
      if (adc.valid && adc.kind == ADC_TEMP) // [RULE20]
      begin
         if (over(temp_d, otw_q[adc.chan]))
         begin
            set_d[adc.chan].byte_temperature = 1'b1; // [RULE13]
            set_d[adc.chan].ot_warn = 1'b1;
         end
         if (over(temp_d, otf_q[adc.chan]))
         begin
            set_d[adc.chan].byte_temperature = 1'b1; // [RULE14]
            set_d[adc.chan].ot_fault = 1'b1;
         end
         if (temp_d < lin_to_fx(utf_q[adc.chan]))
         begin
            set_d[adc.chan].byte_temperature = 1'b1; // [RULE15]
            set_d[adc.chan].ut_fault = 1'b1;
         end
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         status_q <= '0;
      end
      else if (ce)
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            status_q[c] <= (clear ? '0 : status_q[c]) | set_d[c]; // [RULE2]
         end
      end
   end

   assign chan_status = status_q;

   // ****************************************************************
   // Alert pin
   // ****************************************************************
   logic alert_q;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         alert_q <= 1'b0;
      end
      else if (ce)
      begin
         alert_q <= |((status_q[0] | status_q[1]) & ~alert_mask); // [RULE1]
      end
   end

   assign alert_oe = alert_q;
   assign alert_o = 1'b0;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   logic [31:0] resp_cnt_q;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         resp_cnt_q <= '0;
      end
      else if (ce && |set_d && !(|status_q))
      begin
         resp_cnt_q <= resp_cnt_q + 32'h1;
      end
      else
      begin
         resp_cnt_q <= '0;
      end
   end

   sequence iin_write_s;
      ce && cmd.valid && cmd.write && cmd.code == CMD_IN_WARN;
   endsequence

   sequence iin_read_s;
      ce && cmd.valid && !cmd.write && cmd.code == CMD_IN_WARN;
   endsequence

   response_bound_a: assert property ( // [RULE2]
      resp_cnt_q < 32'(RESPONSE_LIMIT_CYC))
      else $error("limit response too slow");

   iin_shared_a: assert property ( // [RULE16]
      iin_write_s ##1 !(ce && cmd.valid && cmd.write) ##1 iin_read_s
      |=> rsp.rdata == $past(cmd.wdata, 3))
      else $error("input current limit not shared by pages");

   iin_warn_a: assert property ( // [RULE1]
      ce && adc.valid && adc.kind == ADC_IIN && over(sample_fx, iwarn_q)
      |=> status_q[0].iin_oc_warn && status_q[1].byte_other
         && status_q[0].word_input)
      else $error("input current warning not set");

   iout_warn_a: assert property ( // [RULE9]
      ce && adc.valid && adc.kind == ADC_IOUT && adc.chan
      && over(sample_fx, owarn_q[1])
      |=> status_q[1].iout_oc_warn && status_q[1].byte_none_above)
      else $error("output current warning not set");

   ramp_gate_a: assert property ( // [RULE8]
      ce && ramping[0] && !clear && !status_q[0].iout_oc_fault
      && !(adc.valid && adc.kind == ADC_IOUT)
      |=> !status_q[0].iout_oc_fault)
      else $error("peak fault set during ramp");

   oc_fault_a: assert property ( // [RULE6]
      $rose(status_q[0].iout_oc_fault)
      |-> $past(cl_sync_q[0]) && !$past(ramping[0]))
      else $error("peak fault without current limit");

   ot_warn_a: assert property ( // [RULE13]
      ce && adc.valid && adc.kind == ADC_TEMP && !adc.chan
      && over(temp_d, otw_q[0])
      |=> status_q[0].ot_warn && status_q[0].byte_temperature)
      else $error("overtemperature warning not set");

   ot_fault_a: assert property ( // [RULE14]
      ce && adc.valid && adc.kind == ADC_TEMP && !adc.chan
      && over(temp_d, otf_q[0])
      |=> status_q[0].ot_fault)
      else $error("overtemperature fault not set");

   ut_fault_a: assert property ( // [RULE15]
      ce && adc.valid && adc.kind == ADC_TEMP && !adc.chan
      && temp_d < lin_to_fx(utf_q[0])
      |=> status_q[0].ut_fault)
      else $error("undertemperature fault not set");

   alert_follow_a: assert property ( // [RULE13]
      ce && |((status_q[0] | status_q[1]) & ~alert_mask)
      |=> alert_oe)
      else $error("alert not driven");
endmodule

// file: lmon_pkg.sv
// Constants and types for the current and temperature limit monitor
// ********************************************************************
// Functional notes
// [RULE1] Input current warning sets OTHER, INPUT, IIN bits, ALERT
// [RULE2] Telemetry limits respond within 120 ms
// [RULE3] Peak limit rounds up to low-range sense steps
// [RULE4] High range uses 37.5 to 75 mV steps
// [RULE5] Range bit 7 of PWM mode selects range
// [RULE6] Fault flagged in current limit, peak not average
// [RULE7] Sense gain scaled by temperature coefficient about 27.0
// [RULE8] Peak fault ignored during rise and fall ramps
// [RULE9] Output current warning sets NONE, IOUT bits, ALERT
// [RULE10] Output warning compares averaged current readback
// [RULE11] Slope trim N from 8192 to 32767, times 2^-14
// [RULE12] Offset trim added to base of -273.15
// [RULE13] Overtemperature warning sets TEMPERATURE bits, ALERT
// [RULE14] Overtemperature fault above programmed limit
// [RULE15] Undertemperature fault below programmed limit
// [RULE16] Input current limit unpaged word, resets 0xD280
// [RULE17] Host sets low UT limit when no sensor
// [RULE18] Limits are linear words, 5-bit exponent, 11-bit mantissa
// [RULE19] Sense gain read as milliohms
// [RULE20] Each new sample re-evaluates its limits
// ********************************************************************
package lmon_pkg;
   localparam int NUM_CHAN = 2;
   localparam int CLK_MHZ = 125;
   localparam int ADC_RESPONSE_MS = 120;
   // Command codes
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h03;
   localparam logic [7:0] CMD_PEAK_FAULT = 8'h46;
   localparam logic [7:0] CMD_OUT_WARN = 8'h4a;
   localparam logic [7:0] CMD_OT_FAULT = 8'h4f;
   localparam logic [7:0] CMD_OT_WARN = 8'h51;
   localparam logic [7:0] CMD_UT_FAULT = 8'h53;
   localparam logic [7:0] CMD_IN_WARN = 8'h5d;
   localparam logic [7:0] CMD_SLOPE_TRIM = 8'hf8;
   localparam logic [7:0] CMD_OFFSET_TRIM = 8'hf9;
   // Reset values
   localparam logic [15:0] RST_PEAK_FAULT = 16'hdbb8;
   localparam logic [15:0] RST_OUT_WARN = 16'hda80;
   localparam logic [15:0] RST_OT_FAULT = 16'heb20;
   localparam logic [15:0] RST_OT_WARN = 16'heaa8;
   localparam logic [15:0] RST_UT_FAULT = 16'he580;
   localparam logic [15:0] RST_IN_WARN = 16'hd280;
   localparam logic [15:0] RST_SLOPE_TRIM = 16'h4000;
   localparam logic [15:0] RST_OFFSET_TRIM = 16'h8000;
   // Linear word layout
   localparam int LIN_MANT_MSB = 10;
   localparam int LIN_EXP_LSB = 11;
   localparam int LIN_EXP_MSB = 15;
   // Fixed point: 48-bit signed, 10 fraction bits
   localparam int FX_W = 48;
   localparam int FX_FRAC = 10;
   localparam int BIG_W = 128;
   // Temperature: -273.15 and 27.0, both scaled by 1024
   localparam logic signed [FX_W-1:0] KELVIN_BASE_FX = -48'sd279706;
   localparam logic signed [FX_W-1:0] TC_NOMINAL_FX = 48'sd27648;
   localparam int SLOPE_SHIFT = 14;
   localparam logic [15:0] SLOPE_MIN = 16'h2000;
   localparam logic [15:0] SLOPE_MAX = 16'h7fff;
   // One million ppm scaled by 1024
   localparam logic signed [63:0] PPM_UNITY_FX = 64'sd1024000000;
   localparam int RANGE_BIT = 7;
   localparam int TENTHS = 10;
   // Sense voltage steps in tenths of a millivolt
   localparam logic [9:0] OC_STEP_LOW [0:7] =
      '{10'd250, 10'd286, 10'd321, 10'd357,
        10'd393, 10'd429, 10'd464, 10'd500};
   localparam logic [9:0] OC_STEP_HIGH [0:7] =
      '{10'd375, 10'd429, 10'd482, 10'd536,
        10'd589, 10'd643, 10'd696, 10'd750};

   typedef enum logic [1:0]
   {
      ADC_IIN = 2'b00,
      ADC_IOUT = 2'b01,
      ADC_TEMP = 2'b10,
      ADC_NONE = 2'b11
   } lmon_adc_kind_type;

   typedef struct packed
   {
      logic valid;
      logic write;
      logic page;
      logic [7:0] code;
      logic [15:0] wdata;
   } lmon_cmd_type;

   typedef struct packed
   {
      logic valid;
      logic err;
      logic [15:0] rdata;
   } lmon_rsp_type;

   typedef struct packed
   {
      logic valid;
      logic chan;
      lmon_adc_kind_type kind;
      logic [15:0] value;
   } lmon_adc_type;

   typedef struct packed
   {
      logic [15:0] pwm_mode_config;
      logic [15:0] current_sense_gain;
      logic [15:0] sense_gain_temp_coefficient;
   } lmon_chan_cfg_type;

   typedef struct packed
   {
      logic byte_other;
      logic byte_none_above;
      logic byte_temperature;
      logic word_input;
      logic word_iout;
      logic iin_oc_warn;
      logic iout_oc_warn;
      logic iout_oc_fault;
      logic ot_warn;
      logic ot_fault;
      logic ut_fault;
   } lmon_status_type;
endpackage

// file: testbench.sv
// Self-checking bench for the limit monitor
`timescale 1ns/10ps
module testbench
   import lmon_pkg::*;
;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   lmon_cmd_type cmd;
   lmon_rsp_type rsp;
   lmon_adc_type adc = '0;
   lmon_chan_cfg_type [NUM_CHAN-1:0] chan_cfg = '0;
   logic [NUM_CHAN-1:0] ramping = '0;
   logic [NUM_CHAN-1:0] current_limit_pin = '0;
   lmon_status_type alert_mask = '0;
   lmon_status_type [NUM_CHAN-1:0] chan_status;
   logic [NUM_CHAN-1:0][2:0] oc_step;
   logic alert_o;
   logic alert_oe;
   lmon_status_type e;
   lmon_rsp_type r;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [7:0] codes [0:7] = '{8'h46, 8'h4a, 8'h4f, 8'h51, 8'h53, 8'h5d,
      8'hf8, 8'hf9};
   logic [15:0] rstv [0:7] = '{16'hdbb8, 16'hda80, 16'heb20, 16'heaa8,
      16'he580, 16'hd280, 16'h4000, 16'h8000};
   logic [2:0] stp [0:2] = '{3'd2, 3'd0, 3'd5};

   always #4 mclk = ~mclk;

   lmon_limit_monitor #(.RESPONSE_LIMIT_CYC(100)) i_lmon_limit_monitor (
      .mclk(mclk), .resetn(resetn), .ce(ce), .cmd(cmd), .rsp(rsp),
      .adc(adc), .chan_cfg(chan_cfg), .ramping(ramping),
      .current_limit_pin(current_limit_pin), .alert_mask(alert_mask),
      .chan_status(chan_status), .oc_step(oc_step), .alert_o(alert_o),
      .alert_oe(alert_oe));

   lmon_host_model i_lmon_host_model (.mclk(mclk), .rsp(rsp), .cmd(cmd));

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
      i_lmon_host_model.xfer(1'b1, p, c, d, r);
   endtask

   task automatic rd(input logic p, input logic [7:0] c);
      i_lmon_host_model.xfer(1'b0, p, c, 16'h0000, r);
   endtask

   task automatic sample(input logic ch, input lmon_adc_kind_type k,
      input logic [15:0] v);
      adc = '{valid: 1'b1, chan: ch, kind: k, value: v};
      @(posedge mclk);
      #1;
      adc = '0;
      @(posedge mclk);
      #1;
   endtask

   task automatic wrap_up;
      if (n_mismatch == 0 && n_tests > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial
   begin
      #200000;
      n_mismatch++;
      wrap_up();
   end

   // ********************************
   // Test sequence
   // ********************************
   initial
   begin
      chan_cfg[0].current_sense_gain = 16'h0001;
      chan_cfg[1].current_sense_gain = 16'h0001;
      repeat (6) @(posedge mclk);
      #1;
      resetn = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         rd(i[3], codes[i%8]);
         check("reset value", r.rdata, rstv[i%8]);
      end
      wr(1'b1, 8'h4a, 16'hdb00);
      rd(1'b0, 8'h4a);
      check("page0 warn", r.rdata, 16'hda80);
      wr(1'b1, 8'h5d, 16'hd300);
      rd(1'b0, 8'h5d);
      check("unpaged in warn", r.rdata, 16'hd300);
      wr(1'b1, 8'h5d, 16'hd280);
      wr(1'b0, 8'h7e, 16'h1234);
      check("unknown err", {15'h0, r.err}, 16'h0001);
      check("rsp valid", {15'h0, r.valid}, 16'h0001);
      for (int i = 0; i < 3; i++)
      begin
         chan_cfg[1].pwm_mode_config = (i > 0) ? 16'h0080 : 16'h0000;
         chan_cfg[1].current_sense_gain = (i > 1) ? 16'h0002 : 16'h0001;
         repeat (3) @(posedge mclk);
         #1;
         check("oc step", 16'(oc_step[1]), 16'(stp[i]));
      end
      sample(1'b0, ADC_IIN, 16'hd300);
      e = '{byte_other: 1'b1, word_input: 1'b1, iin_oc_warn: 1'b1,
         default: 1'b0};
      check("status1 iin", 16'(chan_status[1]), 16'(e));
      @(posedge mclk);
      #1;
      check("alert iin", 16'(alert_oe), 16'h0001);
      check("alert data", 16'(alert_o), 16'h0000);
      wr(1'b0, CMD_CLEAR_STATUS, 16'h0000);
      alert_mask = '{byte_none_above: 1'b1, word_iout: 1'b1,
         iout_oc_warn: 1'b1, default: 1'b0};
      sample(1'b1, ADC_IOUT, 16'hdb00);
      check("iout equal", 16'(chan_status[1]), 16'h0000);
      sample(1'b1, ADC_IOUT, 16'hdb40);
      @(posedge mclk);
      #1;
      e = '{byte_none_above: 1'b1, word_iout: 1'b1, iout_oc_warn: 1'b1,
         default: 1'b0};
      check("status1 iout", 16'(chan_status[1]), 16'(e));
      check("status0 iout", 16'(chan_status[0]), 16'h0000);
      check("alert masked", 16'(alert_oe), 16'h0000);
      wr(1'b0, CMD_CLEAR_STATUS, 16'h0000);
      alert_mask = '0;
      ramping[0] = 1'b1;
      current_limit_pin[0] = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      check("fault in ramp", 16'(chan_status[0]), 16'h0000);
      ramping[0] = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      current_limit_pin[0] = 1'b0;
      e = '{word_iout: 1'b1, iout_oc_fault: 1'b1, default: 1'b0};
      check("peak fault", 16'(chan_status[0]), 16'(e));
      check("peak fault ch1", 16'(chan_status[1]), 16'h0000);
      repeat (3) @(posedge mclk);
      #1;
      wr(1'b0, CMD_CLEAR_STATUS, 16'h0000);
      sample(1'b0, ADC_TEMP, 16'h0190);
      e = '{byte_temperature: 1'b1, ot_warn: 1'b1, ot_fault: 1'b1,
         default: 1'b0};
      check("hot status", 16'(chan_status[0]), 16'(e));
      check("hot ch1", 16'(chan_status[1]), 16'h0000);
      chan_cfg[0].sense_gain_temp_coefficient = 16'h7fff;
      repeat (3) @(posedge mclk);
      #1;
      check("tc step", 16'(oc_step[0]), 16'h0007);
      chan_cfg[0].sense_gain_temp_coefficient = 16'h0000;
      wr(1'b0, CMD_CLEAR_STATUS, 16'h0000);
      wr(1'b0, 8'hf8, 16'h2000);
      sample(1'b0, ADC_TEMP, 16'h0190);
      e = '{byte_temperature: 1'b1, ut_fault: 1'b1, default: 1'b0};
      check("cold status", 16'(chan_status[0]), 16'(e));
      wr(1'b0, CMD_CLEAR_STATUS, 16'h0000);
      i_lmon_host_model.no_sensor_setup(1'b0);
      sample(1'b0, ADC_TEMP, 16'h0000);
      check("no sensor", 16'(chan_status[0]), 16'h0000);
      rd(1'b0, CMD_CLEAR_STATUS);
      check("status read err", {15'h0, r.err}, 16'h0001);
      ce = 1'b0;
      sample(1'b0, ADC_IIN, 16'hd300);
      check("frozen", 16'(chan_status[0]), 16'h0000);
      ce = 1'b1;
      wrap_up();
   end
endmodule
